//--- core/smd_regs.svh
// Purpose: Constants for the lane subtract and long multiply-accumulate path
// Assumes: 32-bit operands, 64-bit accumulator pair
// Notes:   Opcode encodings are local to this datapath
`ifndef SMD_REGS_SVH
`define SMD_REGS_SVH

`define SMD_WORD_W        32
`define SMD_HALF_W        16
`define SMD_BYTE_W        8
`define SMD_ACC_W         64
`define SMD_HALF_LO_MSB   15
`define SMD_HALF_HI_LSB   16
`define SMD_HALF_HI_MSB   31
`define SMD_REG_STACK     4'hD
`define SMD_REG_PROG_CNT  4'hF
`define SMD_FLAGS_RESET   4'h0
`define SMD_MUL_LATENCY   1

`endif

//--- core/smd_pkg.sv
// Purpose: Types for the lane subtract and long multiply-accumulate path
// Assumes: Widths are fixed literals, no header is included
// Notes:   Opcodes are one-hot in the decoder request
package smd_pkg;

   typedef enum logic [8:0] {
      SMD_OP_SUB_HALF = 9'h001,
      SMD_OP_SUB_BYTE = 9'h002,
      SMD_OP_MAC_WORD = 9'h004,
      SMD_OP_MAC_BB   = 9'h008,
      SMD_OP_MAC_BT   = 9'h010,
      SMD_OP_MAC_TB   = 9'h020,
      SMD_OP_MAC_TT   = 9'h040,
      SMD_OP_DUAL     = 9'h080,
      SMD_OP_DUAL_X   = 9'h100
   } smd_op_type;

   typedef struct packed {
      smd_op_type  op;
      logic        cond_pass;
      logic [3:0]  dest_idx;
      logic [3:0]  first_idx;
      logic [3:0]  second_idx;
      logic [31:0] first_operand_reg;
      logic [31:0] second_operand_reg;
      logic [31:0] acc_low_reg;
      logic [31:0] acc_high_reg;
      logic [3:0]  flags;
   } smd_req_type;

   typedef struct packed {
      logic        wr_single;
      logic        wr_pair;
      logic [31:0] result_low;
      logic [31:0] result_high;
      logic [3:0]  flags;
      logic        illegal_reg;
   } smd_rsp_type;

endpackage : smd_pkg

//--- core/smd_mul16.sv
// Purpose: Signed 16 by 16 multiplier with 64-bit sign extension
// Assumes: Operands are two's complement halfwords
// Notes:   Purely combinational
`timescale 1ns/10ps
`include "smd_regs.svh"
module smd_mul16
   import smd_pkg::*;
(
   input  wire logic [15:0] a,
   input  wire logic [15:0] b,
   output logic      [63:0] product
);
   logic signed [31:0] prod32;

   // Signed halfword product, then sign-extend
   assign prod32  = $signed(a) * $signed(b);
   assign product = {{32{prod32[31]}}, prod32};
endmodule : smd_mul16

//--- core/smd_datapath.sv
// Purpose: Lane-wise unsigned subtract and signed long multiply-accumulate
// Assumes: Decoder supplies operands, accumulator pair and condition pass
// Notes:   Result registered one cycle after a valid request
`timescale 1ns/10ps
`include "smd_regs.svh"
module smd_datapath
   import smd_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        reset,
   input  wire logic        req_valid,
   input  smd_req_type      req,
   output logic             rsp_valid,
   output smd_rsp_type      rsp
);

   logic [31:0] op_a;
   logic [31:0] op_b;
   logic [63:0] acc_in;
   logic [31:0] sub_half;
   logic [31:0] sub_byte;
   logic [15:0] sel_a;
   logic [15:0] sel_b;
   logic [15:0] dual_b_hi;
   logic [15:0] dual_b_lo;
   logic [63:0] prod_sel;
   logic [63:0] prod_hi;
   logic [63:0] prod_lo;
   logic [63:0] prod_word;
   logic [63:0] wide_a;
   logic [63:0] wide_b;
   logic [63:0] next_acc;
   logic        is_sub;
   logic        bad_reg;
   smd_rsp_type next_rsp;

   assign op_a   = req.first_operand_reg;
   assign op_b   = req.second_operand_reg;
   assign acc_in = {req.acc_high_reg, req.acc_low_reg};

   // Halfword lanes
   genvar gh;
   generate
      for (gh = 0; gh < 2; gh++) begin : g_half
         assign sub_half[gh*16 +: 16] =
            op_a[gh*16 +: 16] - op_b[gh*16 +: 16];
      end
   endgenerate

   // Byte lanes
   genvar gb;
   generate
      for (gb = 0; gb < 4; gb++) begin : g_byte
         assign sub_byte[gb*8 +: 8] =
            op_a[gb*8 +: 8] - op_b[gb*8 +: 8];
      end
   endgenerate

   // Halfword selection, only the chosen half reaches the multiplier
   always_comb begin
      sel_a = op_a[`SMD_HALF_LO_MSB:0];
      sel_b = op_b[`SMD_HALF_LO_MSB:0];
      if (req.op == SMD_OP_MAC_TB || req.op == SMD_OP_MAC_TT) begin
         sel_a = op_a[`SMD_HALF_HI_MSB:`SMD_HALF_HI_LSB];
      end
      if (req.op == SMD_OP_MAC_BT || req.op == SMD_OP_MAC_TT) begin
         sel_b = op_b[`SMD_HALF_HI_MSB:`SMD_HALF_HI_LSB];
      end
   end

   // Dual pairing of the second operand halves
   always_comb begin
      if (req.op == SMD_OP_DUAL_X) begin
         dual_b_hi = op_b[15:0];
         dual_b_lo = op_b[31:16];
      end else begin
         dual_b_hi = op_b[31:16];
         dual_b_lo = op_b[15:0];
      end
   end

   smd_mul16 u_mul_sel (
      .a       (sel_a),
      .b       (sel_b),
      .product (prod_sel)
   );

   smd_mul16 u_mul_hi (
      .a       (op_a[31:16]),
      .b       (dual_b_hi),
      .product (prod_hi)
   );

   smd_mul16 u_mul_lo (
      .a       (op_a[15:0]),
      .b       (dual_b_lo),
      .product (prod_lo)
   );

   // Full-width signed operands so the product is never cut to 32 bits
   assign wide_a    = {{32{op_a[31]}}, op_a};
   assign wide_b    = {{32{op_b[31]}}, op_b};
   assign prod_word = $signed(wide_a) * $signed(wide_b);

   // Accumulate by form
   always_comb begin
      next_acc = acc_in;
      unique case (req.op)
         SMD_OP_MAC_WORD: begin
            next_acc = acc_in + prod_word;
         end
         SMD_OP_MAC_BB, SMD_OP_MAC_BT,
         SMD_OP_MAC_TB, SMD_OP_MAC_TT: begin
            next_acc = acc_in + prod_sel;
         end
         SMD_OP_DUAL, SMD_OP_DUAL_X: begin
            next_acc = acc_in + prod_hi + prod_lo;
         end
         default: begin
            next_acc = acc_in;
         end
      endcase
   end

   assign is_sub = (req.op == SMD_OP_SUB_HALF) ||
                   (req.op == SMD_OP_SUB_BYTE);

   // Flag misuse of stack or program counter in subtracts
   assign bad_reg = is_sub &&
      (req.dest_idx == `SMD_REG_STACK ||
       req.dest_idx == `SMD_REG_PROG_CNT ||
       req.first_idx == `SMD_REG_STACK ||
       req.first_idx == `SMD_REG_PROG_CNT ||
       req.second_idx == `SMD_REG_STACK ||
       req.second_idx == `SMD_REG_PROG_CNT);

   // Response assembly
   always_comb begin
      next_rsp             = '0;
      next_rsp.flags       = req.flags;
      next_rsp.illegal_reg = bad_reg;
      if (req.op == SMD_OP_SUB_HALF) begin
         next_rsp.result_low = sub_half;
      end else if (req.op == SMD_OP_SUB_BYTE) begin
         next_rsp.result_low = sub_byte;
      end else begin
         next_rsp.result_low  = next_acc[31:0];
         next_rsp.result_high = next_acc[63:32];
      end
      if (req.cond_pass) begin
         next_rsp.wr_single = is_sub && !bad_reg;
         next_rsp.wr_pair   = !is_sub;
      end else begin
         next_rsp.wr_single = 1'b0;
         next_rsp.wr_pair   = 1'b0;
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         rsp_valid <= 1'b0;
      end else begin
         rsp_valid <= req_valid;
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         rsp <= '0;
      end else if (req_valid) begin
         rsp <= next_rsp;
      end else begin
         rsp.wr_single <= 1'b0;
         rsp.wr_pair   <= 1'b0;
      end
   end

endmodule : smd_datapath

//--- testbench/smd_datapath_assertions.sv
// Purpose: Port checker for the subtract and long accumulate path
// Assumes: Sees only the datapath ports
// Notes:   Last request is held in helper logic
`timescale 1ns/10ps
module smd_datapath_assertions
   import smd_pkg::*;
(
   input wire logic   ref_clk,
   input wire logic   reset,
   input wire logic   req_valid,
   input smd_req_type req,
   input wire logic   rsp_valid,
   input smd_rsp_type rsp
);
   smd_req_type        p;
   logic               pv;
   logic        [63:0] r;
   logic        [63:0] acc;
   logic signed [63:0] pw;
   logic signed [63:0] pbt;
   logic signed [63:0] pdx;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset)
         pv <= 1'b0;
      else
         pv <= req_valid && req.cond_pass;
   end
   always_ff @(posedge ref_clk) begin
      p <= req;
   end
   assign r   = {rsp.result_high, rsp.result_low};
   assign acc = {p.acc_high_reg, p.acc_low_reg};
   assign pw  = $signed(p.first_operand_reg) * $signed(p.second_operand_reg);
   assign pbt = $signed(p.first_operand_reg[15:0])
              * $signed(p.second_operand_reg[31:16]);
   assign pdx = $signed(p.first_operand_reg[15:0])
              * $signed(p.second_operand_reg[31:16])
              + $signed(p.first_operand_reg[31:16])
              * $signed(p.second_operand_reg[15:0]);
   sub_half_a: assert property (pv && p.op == SMD_OP_SUB_HALF && rsp.wr_single
      |-> rsp.result_low == {p.first_operand_reg[31:16]
      - p.second_operand_reg[31:16], p.first_operand_reg[15:0]
      - p.second_operand_reg[15:0]}) else $error("halfword lanes wrong");
   sub_byte_a: assert property (pv && p.op == SMD_OP_SUB_BYTE && rsp.wr_single
      |-> rsp.result_low[7:0] == p.first_operand_reg[7:0]
      - p.second_operand_reg[7:0]) else $error("byte lane wrong");
   flags_keep_a: assert property (req_valid |=> rsp.flags == $past(req.flags))
      else $error("flags changed");
   reserved_reg_a: assert property (req_valid && req.op == SMD_OP_SUB_HALF
      && req.dest_idx == 4'hD |=> rsp.illegal_reg && !rsp.wr_single)
      else $error("stack index written");
   mac_word_a: assert property (pv && p.op == SMD_OP_MAC_WORD
      |-> r == acc + pw) else $error("word sum wrong");
   pair_write_a: assert property (req_valid && req.cond_pass
      && req.op == SMD_OP_DUAL |=> rsp_valid && rsp.wr_pair && !rsp.wr_single)
      else $error("pair not written");
   half_sel_a: assert property (pv && p.op == SMD_OP_MAC_BT |-> r == acc + pbt)
      else $error("selected halves wrong");
   dual_x_a: assert property (pv && p.op == SMD_OP_DUAL_X |-> r == acc + pdx)
      else $error("crossed dual wrong");
   cond_fail_a: assert property (req_valid && !req.cond_pass
      |=> rsp_valid && !rsp.wr_single && !rsp.wr_pair)
      else $error("failed condition wrote");
endmodule : smd_datapath_assertions
bind smd_datapath smd_datapath_assertions smd_datapath_assertions_inst (
   .ref_clk(ref_clk), .reset(reset), .req_valid(req_valid), .req(req),
   .rsp_valid(rsp_valid), .rsp(rsp));

//--- testbench/smd_decoder_model.sv
// Purpose: Decoder side that issues one request per command
// Assumes: Bench supplies the decoded operands
// Notes:   Request is registered, one cycle pulse
`timescale 1ns/10ps
module smd_decoder_model
   import smd_pkg::*;
(
   input wire logic   ref_clk,
   input wire logic   go,
   input smd_req_type req_in,
   output logic       req_valid,
   output smd_req_type req
);
   always_ff @(posedge ref_clk) begin
      req_valid <= go;
      req       <= go ? req_in : ~req;
   end
endmodule : smd_decoder_model

//--- testbench/test_smd_datapath.sv
// Purpose: Self-checking bench for the datapath
// Assumes: One request in flight at a time
// Notes:   Expected values are worked by hand
`timescale 1ns/10ps
module test_smd_datapath;
   import smd_pkg::*;
   logic        ref_clk = 1'b0;
   logic        reset   = 1'b1;
   logic        go      = 1'b0;
   smd_req_type req_in  = '0;
   logic        req_valid;
   smd_req_type req;
   logic        rsp_valid;
   smd_rsp_type rsp;
   int          errors  = 0;
   int          num_checks = 0;
   always #4 ref_clk = ~ref_clk;
   smd_decoder_model smd_decoder_model_inst (.ref_clk(ref_clk), .go(go),
      .req_in(req_in), .req_valid(req_valid), .req(req));
   smd_datapath smd_datapath_inst (.ref_clk(ref_clk), .reset(reset),
      .req_valid(req_valid), .req(req), .rsp_valid(rsp_valid), .rsp(rsp));
   task automatic chk(input logic [63:0] g, input logic [63:0] e);
      num_checks++;
      if (g !== e) begin
         errors++;
         $display("BAD %0t got %h want %h", $time, g, e);
      end
   endtask : chk
   task automatic run(input smd_op_type op, input logic [31:0] a, b,
                      input logic [63:0] acc, input logic c, d);
      int n;
      @(posedge ref_clk);
      go     <= 1'b1;
      req_in <= '{op, c, d ? 4'hD : 4'h1, 4'h2, 4'h3, a, b,
                  acc[31:0], acc[63:32], 4'hA};
      @(posedge ref_clk);
      go <= 1'b0;
      n = 0;
      do begin
         @(posedge ref_clk);
         #1;
         n++;
      end while (rsp_valid !== 1'b1 && n < 8);
      chk(rsp_valid, 1);
      chk(rsp.flags, 64'hA);
   endtask : run
   task automatic t_sub;
      run(SMD_OP_SUB_HALF, 32'h00050003, 32'h00010004, 0, 1, 0);
      chk(rsp.result_low, 64'h0004FFFF);
      run(SMD_OP_SUB_BYTE, 32'h1000FF02, 32'h01010103, 0, 1, 0);
      chk(rsp.result_low, 64'h0FFFFEFF);
      chk(rsp.wr_single, 1);
      chk({rsp.illegal_reg, rsp.wr_pair, rsp.result_high}, 0);
      $display("t_sub done");
   endtask : t_sub
   task automatic t_mac;
      smd_op_type  o [4];
      logic [63:0] e [4];
      o = '{SMD_OP_MAC_BB, SMD_OP_MAC_BT, SMD_OP_MAC_TB, SMD_OP_MAC_TT};
      e = '{64'h12, 64'h6, 64'hD, 64'h1F};
      run(SMD_OP_MAC_WORD, 32'hFFFFFFFE, 32'h3, 64'h100000000, 1, 0);
      chk({rsp.result_high, rsp.result_low}, 64'hFFFFFFFA);
      chk(rsp.wr_pair, 1);
      for (int i = 0; i < 4; i++) begin
         run(o[i], 32'h0003FFFE, 32'h0005FFFF, 64'h10, 1, 0);
         chk({rsp.result_high, rsp.result_low}, e[i]);
      end
      run(SMD_OP_DUAL, 32'h0003FFFE, 32'h0005FFFF, 64'hFFFFFFFF, 1, 0);
      chk({rsp.result_high, rsp.result_low}, 64'h100000010);
      run(SMD_OP_DUAL_X, 32'h0003FFFE, 32'h0005FFFF, 64'hFFFFFFFF, 1, 0);
      chk({rsp.result_high, rsp.result_low}, 64'hFFFFFFF2);
      $display("t_mac done");
   endtask : t_mac
   task automatic t_refuse;
      run(SMD_OP_MAC_WORD, 32'h5, 32'h7, 64'h1, 0, 0);
      chk({rsp.wr_single, rsp.wr_pair}, 0);
      run(SMD_OP_SUB_HALF, 32'h5, 32'h1, 0, 1, 1);
      chk({rsp.illegal_reg, rsp.wr_single}, 64'h2);
      $display("t_refuse done");
   endtask : t_refuse
   task automatic wrap_up;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : wrap_up
   initial begin
      #20000;
      errors++;
      wrap_up();
   end
   initial begin
      repeat (20) @(posedge ref_clk);
      reset <= 1'b0;
      t_sub();
      t_mac();
      t_refuse();
      wrap_up();
   end
endmodule : test_smd_datapath
